// ===== logic/sirm_pkg.sv
// package for the supply integrity reset monitor: register layout, reset values and timing counts
// assumes one 100 MHz cpu clock and a plain strobe register port
package sirm_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] SIRM_ADDR_CSR = 4'h0;
    localparam logic [7:0] SIRM_CSR_RESET = 8'h00;
    localparam int SIRM_BIT_SRC_SEL = 7;
    localparam int SIRM_BIT_IRQ_EN = 6;
    localparam int SIRM_BIT_WARN_FLAG = 5;
    localparam int SIRM_BIT_UV_FLAG = 4;
    localparam int SIRM_BIT_WD_FLAG = 0;

    // ****************************************
    // timing
    // ****************************************
    localparam int SIRM_CLK_MHZ = 100;
    localparam int SIRM_RST_PULSE_NS = 20000;
    localparam logic [12:0] SIRM_RST_PULSE_CYC = 13'((SIRM_RST_PULSE_NS * SIRM_CLK_MHZ + 999) / 1000);
    localparam logic [12:0] SIRM_DELAY_SHORT = 13'h0100;
    localparam logic [12:0] SIRM_DELAY_LONG = 13'h1000;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        SIRM_RUN = 2'b00,
        SIRM_ACTIVE = 2'b01,
        SIRM_DELAY = 2'b10
    } sirm_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sirm_bus_t;

    typedef struct packed {
        sirm_state_t st;
        logic [12:0] cnt;
        logic src_sel;
        logic irq_en;
        logic uv_flag;
        logic wd_flag;
        logic [1:0] warn_sync;
        logic [1:0] uv_sync;
        logic warn_flag;
        logic irq_pend;
        logic uv_seen;
        logic wd_seen;
        logic [7:0] rdata;
        logic rst_pin_oe;
        logic cpu_rst;
        logic irq;
        logic wake;
    } sirm_state_all_t;

endpackage

// ===== logic/sirm_monitor.sv
// supply integrity reset monitor: undervoltage reset, watchdog reset pulse, voltage warning flag
// assumes comparator outputs and reset pin arrive asynchronously; watchdog, cpu and bus are on i_clk
// How it works
// - watchdog underflow pulls reset pin low at least the minimum pulse time
// - undervoltage comparator output holds static reset; hysteresis lives in the analog comparator
// - threshold level low/medium/high passes out from option setting to comparator
// - reset pin stays driven low while undervoltage reset is active
// - undervoltage detector and warning only work when option enables them
// - bit 5 is read-only synchronised warning comparator output
// - bit 7 selects main supply or external sense pin for warning comparator
// - with bit 6 set, every warning flag change outside reset raises an interrupt
// - pending warning interrupt clears when cpu enters its service routine
// - warning crossing during reset delay gives no interrupt
// - enabling interrupt while flag set gives one interrupt, crossing another
// - enabling interrupt after crossing gives exactly one interrupt
// - in wait mode logic runs and a warning interrupt wakes the cpu
// - in halt mode the register is frozen and warnings do not wake
// - interrupt reaches cpu only when enabled and cpu mask is clear
// - watchdog flag set on watchdog reset, cleared by zero write or undervoltage reset
// - undervoltage flag survives later pin or watchdog resets
// - flags encode source: 00 pin, 01 watchdog, 1x undervoltage
// - after active phase, reset held 256 or 4096 cycles by option
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module sirm_monitor
    import sirm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_opt_uv_enable,
    input wire logic [1:0] i_opt_uv_level,
    input wire logic i_opt_long_delay,
    input wire logic i_uv_below,
    input wire logic i_warn_below,
    input wire logic i_wd_underflow,
    input wire logic i_rst_pin_in,
    input wire logic i_cpu_irq_masked,
    input wire logic i_irq_ack,
    input wire logic i_halt,
    output logic [7:0] o_rdata,
    output logic o_rst_pin_out,
    output logic o_rst_pin_oe,
    output logic o_cpu_rst,
    output logic o_irq,
    output logic o_wake,
    output logic o_warn_src_sel,
    output logic [1:0] o_uv_level
);

    // ****************************************
    // state
    // ****************************************
    sirm_state_all_t s_q;
    sirm_state_all_t s_d;
    sirm_bus_t bus;
    logic [1:0] pin_sync_q;
    logic [1:0] level_q;
    logic [1:0] oe_dly_q;
    logic uv_active;
    logic warn_edge;
    logic en_rise;
    logic pin_low;
    logic [12:0] delay_cyc;

    // bus fields travel together
    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // pin sync and strap copy sit outside the state struct; option strap is caught by a clock edge
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_sync_q <= 2'h3;
            level_q <= 2'h0;
            oe_dly_q <= 2'h3;
        end else begin
            pin_sync_q <= {pin_sync_q[0], i_rst_pin_in};
            oe_dly_q <= {oe_dly_q[0], s_q.rst_pin_oe};
            level_q <= i_opt_uv_level;
        end
    end

    // second-stage samples only; first stages feed nothing else
    assign uv_active = i_opt_uv_enable & s_q.uv_sync[1];
    // our own release takes two sync stages to read back high; ignore the pin until then,
    // otherwise the monitor would retrigger itself forever
    assign pin_low = ~pin_sync_q[1] & ~|oe_dly_q;
    assign delay_cyc = i_opt_long_delay ? SIRM_DELAY_LONG : SIRM_DELAY_SHORT;
    // flag change edge; the pending logic ignores it while cpu is in reset so a fast rise gives none
    assign warn_edge = (s_q.warn_sync[1] != s_q.warn_flag);
    assign en_rise = bus.wr && (bus.addr == SIRM_ADDR_CSR) && bus.wdata[SIRM_BIT_IRQ_EN] && !s_q.irq_en;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.warn_sync = {s_q.warn_sync[0], i_warn_below & i_opt_uv_enable};
        s_d.uv_sync = {s_q.uv_sync[0], i_uv_below};
        s_d.rdata = 8'h00;

        // reset sequencer
        case (s_q.st)
            SIRM_RUN: begin
                if (uv_active) begin
                    s_d.st = SIRM_ACTIVE;
                    s_d.uv_seen = 1'b1;
                end else if (i_wd_underflow) begin
                    s_d.st = SIRM_ACTIVE;
                    s_d.cnt = SIRM_RST_PULSE_CYC;
                    s_d.wd_seen = 1'b1;
                end else if (pin_low) begin
                    s_d.st = SIRM_ACTIVE;
                    s_d.cnt = SIRM_RST_PULSE_CYC;
                end
            end
            SIRM_ACTIVE: begin
                if (uv_active) begin
                    s_d.cnt = 13'h0000; // static reset until supply recovers
                    s_d.uv_seen = 1'b1; // a drop during another reset still counts
                end else if (s_q.cnt > 13'h0001) begin
                    s_d.cnt = s_q.cnt - 13'h0001;
                end else if (!pin_low || s_q.rst_pin_oe) begin
                    s_d.st = SIRM_DELAY;
                    s_d.cnt = delay_cyc;
                end
            end
            SIRM_DELAY: begin
                if (uv_active) begin
                    s_d.st = SIRM_ACTIVE;
                    s_d.uv_seen = 1'b1;
                end else if (s_q.cnt > 13'h0001) begin
                    s_d.cnt = s_q.cnt - 13'h0001;
                end else begin
                    s_d.st = SIRM_RUN;
                    s_d.cnt = 13'h0000;
                end
            end
            default: begin
                s_d.st = SIRM_ACTIVE;
            end
        endcase
        // pin driven low through active and delay phases
        s_d.rst_pin_oe = (s_d.st != SIRM_RUN);
        s_d.cpu_rst = (s_d.st != SIRM_RUN);

        // reset source flags latched on leaving reset so cpu sees them at restart
        if (s_q.st == SIRM_DELAY && s_d.st == SIRM_RUN) begin
            if (s_q.uv_seen) begin
                s_d.uv_flag = 1'b1;
                s_d.wd_flag = 1'b0;
            end else if (s_q.wd_seen) begin
                s_d.wd_flag = 1'b1;
            end
            s_d.uv_seen = 1'b0;
            s_d.wd_seen = 1'b0;
        end

        // warning flag follows comparator; edges only count with the cpu out of reset
        if (!i_halt) begin
            s_d.warn_flag = s_q.warn_sync[1];
        end
        if (s_q.cpu_rst) begin
            s_d.irq_pend = 1'b0;
        end

        // register access; halt freezes the register contents
        if (bus.wr && bus.addr == SIRM_ADDR_CSR && !i_halt && !s_q.cpu_rst) begin
            s_d.src_sel = bus.wdata[SIRM_BIT_SRC_SEL];
            s_d.irq_en = bus.wdata[SIRM_BIT_IRQ_EN];
            // zero clears, one
            s_d.uv_flag = s_d.uv_flag & bus.wdata[SIRM_BIT_UV_FLAG];
            s_d.wd_flag = s_d.wd_flag & bus.wdata[SIRM_BIT_WD_FLAG];
        end
        if (bus.rd) begin
            if (bus.addr == SIRM_ADDR_CSR) begin
                s_d.rdata = {s_q.src_sel, s_q.irq_en, s_q.warn_flag,
                    s_q.uv_flag & i_opt_uv_enable, 3'h0, s_q.wd_flag};
            end
        end

        // interrupt pending: ack clears, a new event in the same cycle wins
        if (i_irq_ack) begin
            s_d.irq_pend = 1'b0;
        end
        if (!s_q.cpu_rst && !i_halt) begin
            if ((warn_edge && s_q.irq_en) || (en_rise && s_q.warn_flag)) begin
                s_d.irq_pend = 1'b1;
            end
        end
        if (!s_d.irq_en) begin
            s_d.irq_pend = 1'b0;
        end
        s_d.irq = s_d.irq_pend & ~i_cpu_irq_masked;
        s_d.wake = s_d.irq_pend & ~i_halt;
    end

    // state register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= '{st: SIRM_ACTIVE, cnt: SIRM_RST_PULSE_CYC, src_sel: SIRM_CSR_RESET[SIRM_BIT_SRC_SEL],
                irq_en: SIRM_CSR_RESET[SIRM_BIT_IRQ_EN], uv_flag: SIRM_CSR_RESET[SIRM_BIT_UV_FLAG],
                wd_flag: SIRM_CSR_RESET[SIRM_BIT_WD_FLAG], warn_sync: 2'h0, uv_sync: 2'h0,
                warn_flag: 1'b0, irq_pend: 1'b0, uv_seen: 1'b0, wd_seen: 1'b0, rdata: 8'h00,
                rst_pin_oe: 1'b1, cpu_rst: 1'b1, irq: 1'b0, wake: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops; pin output level is always low, oe drives it
    assign o_rdata = s_q.rdata;
    assign o_rst_pin_out = 1'b0;
    assign o_rst_pin_oe = s_q.rst_pin_oe;
    assign o_cpu_rst = s_q.cpu_rst;
    assign o_irq = s_q.irq;
    assign o_wake = s_q.wake;
    assign o_warn_src_sel = s_q.src_sel;
    assign o_uv_level = level_q;

    // ****************************************
    // checks
    // ****************************************
    sequence wd_hit;
        (s_q.st == SIRM_RUN) && i_wd_underflow && !uv_active;
    endsequence

    chk_wd_pin_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        wd_hit |=> o_rst_pin_oe [*8])
        else $error("reset pin released too early after watchdog underflow");
    chk_uv_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        uv_active |=> o_rst_pin_oe && o_cpu_rst)
        else $error("reset pin not held during undervoltage");
    chk_delay_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (s_q.st == SIRM_ACTIVE && s_d.st == SIRM_DELAY && !i_opt_long_delay) |=> o_cpu_rst [*8])
        else $error("delay phase ended early");
    chk_warn_ro: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_rd && i_addr == SIRM_ADDR_CSR) |=> o_rdata[SIRM_BIT_WARN_FLAG] == $past(s_q.warn_flag))
        else $error("warning bit read mismatch");
    chk_irq_mask: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_irq |-> !$past(i_cpu_irq_masked) && s_q.irq_en)
        else $error("interrupt while masked or disabled");
    chk_edge_irq: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (warn_edge && s_q.irq_en && !s_q.cpu_rst && !i_halt && !i_wr) |=> s_q.irq_pend)
        else $error("warning change lost its interrupt");
    chk_ack_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_irq_ack && !warn_edge && !en_rise) |=> !s_q.irq_pend)
        else $error("pending not cleared by ack");
    chk_no_irq_reset: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_q.cpu_rst |=> !s_q.irq_pend)
        else $error("interrupt pending during reset");
    chk_flag_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_wr && i_addr == SIRM_ADDR_CSR && i_wdata[SIRM_BIT_UV_FLAG] && s_q.uv_flag) |=> s_q.uv_flag)
        else $error("writing one cleared undervoltage flag");
    chk_halt_frozen: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_halt |=> $stable(s_q.src_sel) && $stable(s_q.irq_en))
        else $error("control bits changed during halt");
    chk_uv_clears_wd: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (s_q.st == SIRM_DELAY && s_d.st == SIRM_RUN && s_q.uv_seen) |=> s_q.uv_flag && !s_q.wd_flag)
        else $error("undervoltage reset left watchdog flag set");

endmodule

// ===== test/sirm_partner.sv
// far side model: cpu entry into the warning service routine and the open-drain reset line
// assumes the monitor's clock and reset; the reset line carries a pull-up
`timescale 1ns/10ps
module sirm_partner (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_irq,
    input wire logic i_pin_oe,
    input wire logic i_ack_en,
    input wire logic i_ext_low,
    output logic o_irq_ack,
    output logic o_pin_level
);
    logic [3:0] ent_q;

    // ****************************************
    // reset line
    // ****************************************
    // pull-up wins only while nobody pulls the line low
    assign o_pin_level = ~(i_pin_oe | i_ext_low);

    // ****************************************
    // service routine entry
    // ****************************************
    // cpu enters a few cycles after the request; the idle gap avoids a double entry
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ent_q <= 4'h0;
        end else begin
            ent_q <= {ent_q[2:0], i_irq & i_ack_en & ~|ent_q};
        end
    end
    assign o_irq_ack = ent_q[2];
endmodule

// ===== test/sirm_monitor_tb.sv
// self-checking bench for the supply integrity reset monitor
// assumes sirm_partner on the far side and a 100 MHz clock
`timescale 1ns/10ps
module sirm_monitor_tb
    import sirm_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, rv;
    logic i_wr, i_rd, i_opt_uv_enable, i_opt_long_delay, i_uv_below, i_warn_below, i_wd_underflow;
    logic i_rst_pin_in, i_cpu_irq_masked, i_irq_ack, i_halt, ack_en, ext_low;
    logic o_rst_pin_out, o_rst_pin_oe, o_cpu_rst, o_irq, o_wake, o_warn_src_sel;
    logic [1:0] i_opt_uv_level, o_uv_level;
    logic [31:0] lfsr_q = 32'h7FC7FA9C;
    int miscompares = 0;
    int tests_run = 0;
    int n, m;

    always #5 i_clk = ~i_clk;

    sirm_monitor dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_opt_uv_enable(i_opt_uv_enable), .i_opt_uv_level(i_opt_uv_level),
        .i_opt_long_delay(i_opt_long_delay), .i_uv_below(i_uv_below), .i_warn_below(i_warn_below),
        .i_wd_underflow(i_wd_underflow), .i_rst_pin_in(i_rst_pin_in), .i_cpu_irq_masked(i_cpu_irq_masked),
        .i_irq_ack(i_irq_ack), .i_halt(i_halt), .o_rdata(o_rdata), .o_rst_pin_out(o_rst_pin_out),
        .o_rst_pin_oe(o_rst_pin_oe), .o_cpu_rst(o_cpu_rst), .o_irq(o_irq), .o_wake(o_wake),
        .o_warn_src_sel(o_warn_src_sel), .o_uv_level(o_uv_level));
    sirm_partner cpu (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_irq(o_irq), .i_pin_oe(o_rst_pin_oe),
        .i_ack_en(ack_en), .i_ext_low(ext_low), .o_irq_ack(i_irq_ack), .o_pin_level(i_rst_pin_in));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // cycles from the reset cause until the cpu runs: pulse plus option delay
    function automatic int dly(input logic lng);
        return int'(SIRM_RST_PULSE_CYC) + (lng ? int'(SIRM_DELAY_LONG) : int'(SIRM_DELAY_SHORT));
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk8({7'h0, got}, {7'h0, exp});
    endtask
    // settle just after an edge so the checks see landed values
    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk8(o_rdata, exp);
    endtask
    task automatic wait_up(output int n, output int m);
        n = 0;
        m = 0;
        while (o_cpu_rst !== 1'b0 && n < 8000) begin
            cyc(1);
            n++;
            m += (o_rst_pin_oe === 1'b1) ? 1 : 0;
        end
        chkb(o_cpu_rst, 1'b0);
    endtask
    task automatic ack_all;
        ack_en <= 1'b1;
        cyc(12);
        ack_en <= 1'b0;
    endtask
    task automatic wd_reset(input logic lng);
        int n, m;
        @(posedge i_clk);
        i_opt_long_delay <= lng;
        i_wd_underflow <= 1'b1;
        @(posedge i_clk);
        i_wd_underflow <= 1'b0;
        #1 chkb(o_rst_pin_oe, 1'b1);
        chkb(o_rst_pin_out, 1'b0);
        wait_up(n, m);
        chkb(m >= int'(SIRM_RST_PULSE_CYC), 1'b1);
        chkb(n >= dly(lng) - 2 && n <= dly(lng) + 8, 1'b1);
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        {i_wr, i_rd, i_wd_underflow, i_uv_below, i_warn_below, i_halt, i_cpu_irq_masked} = '0;
        {ack_en, ext_low, i_addr, i_wdata, i_opt_uv_level, i_opt_long_delay} = '0;
        i_opt_uv_enable = 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        wait_up(n, m);
        chkb(n >= dly(1'b0) - 2 && n <= dly(1'b0) + 8, 1'b1);
        rdc(4'h0, SIRM_CSR_RESET);
        rdc(4'h3, 8'h00);
        for (int k = 0; k < 3; k++) begin
            i_opt_uv_level <= 2'(k);
            cyc(2);
            chk8({6'h0, o_uv_level}, 8'(k));
        end
        // random control values; reserved bits always written as zero
        repeat (8) begin
            lfsr_q = lfsr_next(lfsr_q);
            wr(4'h0, lfsr_q[7:0] & 8'hC0);
            rdc(4'h0, lfsr_q[7:0] & 8'hC0);
            chkb(o_warn_src_sel, lfsr_q[7]);
        end
        wr(4'h0, 8'h40);
        i_warn_below <= 1'b1;
        cyc(8);
        rdc(4'h0, 8'h60);
        chkb(o_irq, 1'b1);
        chkb(o_wake, 1'b1);
        i_cpu_irq_masked <= 1'b1;
        cyc(3);
        chkb(o_irq, 1'b0);
        i_cpu_irq_masked <= 1'b0;
        ack_all();
        chkb(o_irq, 1'b0);
        i_warn_below <= 1'b0;
        cyc(8);
        chkb(o_irq, 1'b1);
        ack_all();
        // enable raised while the flag already stands
        wr(4'h0, 8'h00);
        i_warn_below <= 1'b1;
        cyc(8);
        chkb(o_irq, 1'b0);
        wr(4'h0, 8'h40);
        cyc(4);
        chkb(o_irq, 1'b1);
        ack_all();
        chkb(o_irq, 1'b0);
        i_warn_below <= 1'b0;
        cyc(8);
        chkb(o_irq, 1'b1);
        ack_all();
        // halt freezes the register and never wakes
        i_halt <= 1'b1;
        wr(4'h0, 8'h80);
        rdc(4'h0, 8'h40);
        i_warn_below <= 1'b1;
        cyc(8);
        chkb(o_wake, 1'b0);
        i_halt <= 1'b0;
        cyc(8);
        chkb(o_wake, 1'b1);
        ack_all();
        i_warn_below <= 1'b0;
        cyc(8);
        ack_all();
        wr(4'h0, 8'h00);
        i_opt_uv_enable <= 1'b0;
        i_warn_below <= 1'b1;
        cyc(8);
        rdc(4'h0, 8'h00);
        i_warn_below <= 1'b0;
        i_opt_uv_enable <= 1'b1;
        cyc(8);
        // reset source flags
        wd_reset(1'b0);
        rdc(4'h0, 8'h01);
        wr(4'h0, 8'h11);
        rdc(4'h0, 8'h01);
        wd_reset(1'b1);
        i_uv_below <= 1'b1;
        cyc(300);
        chkb(o_cpu_rst, 1'b1);
        chkb(i_rst_pin_in, 1'b0);
        i_uv_below <= 1'b0;
        wait_up(n, m);
        rdc(4'h0, 8'h10);
        wd_reset(1'b0);
        rdc(4'h0, 8'h11);
        wr(4'h0, 8'h01);
        rdc(4'h0, 8'h01);
        wr(4'h0, 8'h00);
        ext_low <= 1'b1;
        cyc(50);
        ext_low <= 1'b0;
        wait_up(n, m);
        rdc(4'h0, 8'h00);
        final_report();
    end

    // run is about 20k cycles; this cuts a hang short
    initial begin
        #500000;
        miscompares++;
        $display("mismatch at %0t: timeout", $time);
        final_report();
    end
endmodule
